//--- verilog/mtp_pkg.sv
// Shared constants and types for the meter test-mode pulse block.
package mtp_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned CLK_HZ = CLK_MHZ * 1000000;
	localparam int unsigned SECOND_CYCLES = CLK_HZ;
	localparam int unsigned TEST_MODE_HOURS = 9;
	localparam int unsigned TEST_MODE_SECONDS = TEST_MODE_HOURS * 3600;
	localparam int unsigned PULSE_WIDTH_US = 3900;
	localparam int unsigned PULSE_WIDTH_CYCLES = PULSE_WIDTH_US * CLK_MHZ;
	localparam logic [3:0] KEY_HOLD_S = 4'h3;

	// ------------------------------------------------------------------
	// Integration intervals in seconds
	// ------------------------------------------------------------------
	localparam logic [6:0] INTEG_TEST_S = 7'h02;
	localparam logic [6:0] INTEG_FAST2_S = 7'h02;
	localparam logic [6:0] INTEG_FAST8_S = 7'h08;
	localparam logic [6:0] INTEG_NORMAL_S = 7'h20;
	localparam logic [6:0] ADAPT_MIN_S = 7'h02;
	localparam logic [6:0] ADAPT_MAX_S = 7'h40;

	// ------------------------------------------------------------------
	// Integration mode codes
	// ------------------------------------------------------------------
	localparam logic [3:0] MODE_ADAPT_A = 4'h1;
	localparam logic [3:0] MODE_NORMAL_A = 4'h2;
	localparam logic [3:0] MODE_FAST8_A = 4'h3;
	localparam logic [3:0] MODE_FAST2 = 4'h4;
	localparam logic [3:0] MODE_ADAPT_B = 4'h5;
	localparam logic [3:0] MODE_NORMAL_B = 4'h6;
	localparam logic [3:0] MODE_FAST8_B = 4'h7;

	// ------------------------------------------------------------------
	// Nominal flow size bands, in units of 0.1 m3/h
	// ------------------------------------------------------------------
	localparam logic [17:0] SIZE_BAND1 = 18'h0000f;
	localparam logic [17:0] SIZE_BAND2 = 18'h00096;
	localparam logic [17:0] SIZE_BAND3 = 18'h005dc;
	localparam logic [17:0] SIZE_BAND4 = 18'h03a98;

	// ------------------------------------------------------------------
	// Pulse weights in input units (0.001 kWh energy, 0.01 l volume)
	// ------------------------------------------------------------------
	localparam logic [15:0] WEIGHT_BAND1 = 16'h0001;
	localparam logic [15:0] WEIGHT_BAND2 = 16'h000a;
	localparam logic [15:0] WEIGHT_BAND3 = 16'h0064;
	localparam logic [15:0] WEIGHT_BAND4 = 16'h03e8;
	localparam logic [15:0] WEIGHT_BAND5 = 16'h2710;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic {MTP_NORMAL, MTP_TEST} mtp_mode_t;
	typedef enum logic [1:0] {MTP_P_IDLE, MTP_P_HIGH, MTP_P_GAP} mtp_pstate_t;

endpackage

//--- verilog/mtp_sync.sv
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/10ps
module mtp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] stage1;

	// ------------------------------------------------------------------
	// Synchroniser chain
	// ------------------------------------------------------------------
	// The first stage feeds only the second, so metastability settles.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			stage1 <= '0;
			q_out <= '0;
		end else begin
			stage1 <= d_in;
			q_out <= stage1;
		end
	end

endmodule // mtp_sync

//--- verilog/mtp_pulse_chan.sv
// One verification pulse channel: accumulator, queue and pulse timer.
`timescale 1ns/10ps
module mtp_pulse_chan
	import mtp_pkg::*;
#(
	parameter int unsigned WIDTH_CYCLES = PULSE_WIDTH_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic test_en_in,
	input wire logic pulse_en_in,
	input wire logic clear_in,
	input wire logic [15:0] weight_in,
	input wire logic strobe_in,
	input wire logic [15:0] delta_in,
	output logic pulse_out,
	output logic [31:0] count_out
);

	logic [31:0] acc;
	logic [15:0] pending;
	logic [31:0] timer;
	mtp_pstate_t state;
	wire [31:0] add = strobe_in ? {16'h0000, delta_in} : 32'h00000000;
	wire [31:0] sum = acc + add;
	wire unit_hit = test_en_in && (acc >= {16'h0000, weight_in});
	wire queue_inc = unit_hit && pulse_en_in && (pending != 16'hffff);
	wire start = (state == MTP_P_IDLE) && (pending != 16'h0000);
	wire timer_done = (timer == 32'(WIDTH_CYCLES - 1));

	// ------------------------------------------------------------------
	// Accumulator, unit count and pulse queue
	// ------------------------------------------------------------------
	// One weight unit leaves the accumulator per cycle; any surplus stays
	// as queued work, so a burst of energy never merges pulses.
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc <= 32'h00000000;
			count_out <= 32'h00000000;
			pending <= 16'h0000;
		end else begin
			if (!test_en_in) begin
				acc <= 32'h00000000;
			end else if (unit_hit) begin
				acc <= sum - {16'h0000, weight_in};
			end else begin
				acc <= sum;
			end
			if (clear_in) begin
				count_out <= 32'h00000000;
			end else if (unit_hit) begin
				count_out <= count_out + 32'h00000001;
			end
			if (!pulse_en_in) begin
				pending <= 16'h0000;
			end else begin
				pending <= pending + {15'h0000, queue_inc}
					- {15'h0000, start};
			end
		end
	end

	// ------------------------------------------------------------------
	// Pulse timer: fixed high time, then a low gap at least one cycle longer
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= MTP_P_IDLE;
			timer <= 32'h00000000;
			pulse_out <= 1'b0;
		end else begin
			case (state)
				MTP_P_IDLE: begin
					timer <= 32'h00000000;
					if (start) begin
						state <= MTP_P_HIGH;
						pulse_out <= 1'b1;
					end
				end
				MTP_P_HIGH: begin
					timer <= timer + 32'h00000001;
					if (timer_done) begin
						state <= MTP_P_GAP;
						pulse_out <= 1'b0;
						timer <= 32'h00000000;
					end
				end
				MTP_P_GAP: begin
					timer <= timer + 32'h00000001;
					if (timer_done) begin
						state <= MTP_P_IDLE;
					end
				end
				default: begin
					state <= MTP_P_IDLE;
					pulse_out <= 1'b0;
				end
			endcase
		end
	end

endmodule // mtp_pulse_chan

//--- verilog/mtp_top.sv
// Test-mode control and verification pulse outputs of the heat meter.
//
// Functional notes
// - Test switch enters test mode whatever integration mode code is set.
// - Test mode integrates every two seconds, like the fastest setting.
// - Test mode ends after nine hours or on supply restart.
// - In test mode, both arrow keys held until call shows start auto-integration.
// - Mode codes: 1,5 adaptive 2-64 s; 2,6 32 s; 3,7 8 s; 4 2 s.
// - Energy pulse weight follows nominal flow size band, 0.001 kWh to 0.01 MWh.
// - Volume pulse weight follows same bands, 0.01 l to 0.1 m3.
// - Pulses go out only in test mode with adapter fitted; separate outputs.
// - Every verification pulse not cut short by adapter removal or test-mode end is high for 3.9 ms.
// - High-resolution counts are offered to display, serial readout and pulses.
`timescale 1ns/10ps
module mtp_top
	import mtp_pkg::*;
#(
	parameter int unsigned SECOND_CYC = SECOND_CYCLES,
	parameter int unsigned TEST_MODE_S = TEST_MODE_SECONDS,
	parameter int unsigned PULSE_CYC = PULSE_WIDTH_CYCLES
) (
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	input wire logic TEST_SWITCH_IN,
	input wire logic KEY_UP_IN,
	input wire logic KEY_DOWN_IN,
	input wire logic ADAPTER_PRESENT_IN,
	input wire logic [3:0] INTEG_MODE_IN,
	input wire logic [17:0] NOMINAL_FLOW_SIZE_IN,
	input wire logic ENERGY_STROBE_IN,
	input wire logic [15:0] ENERGY_DELTA_IN,
	input wire logic VOLUME_STROBE_IN,
	input wire logic [15:0] VOLUME_DELTA_IN,
	output logic TEST_MODE_OUT,
	output logic PULSE_ENABLE_OUT,
	output logic INTEG_TICK_OUT,
	output logic [6:0] INTEG_INTERVAL_OUT,
	output logic CALL_IND_OUT,
	output logic AUTO_INTEG_OUT,
	output logic ENERGY_PULSE_OUT,
	output logic VOLUME_PULSE_OUT,
	output logic [31:0] ENERGY_COUNT_OUT,
	output logic [31:0] VOLUME_COUNT_OUT
);

	// ------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------
	logic [3:0] pins_sync;
	wire sw_sync = pins_sync[0];
	wire up_sync = pins_sync[1];
	wire down_sync = pins_sync[2];
	wire adapter_sync = pins_sync[3];

	// All four pins are mechanical or external, so each is synchronised.
	mtp_sync #(
		.WIDTH(4)
	) u_pin_sync (
		.clk_in(CORE_CLK_IN),
		.rst_in(RST_IN),
		.d_in({ADAPTER_PRESENT_IN, KEY_DOWN_IN, KEY_UP_IN, TEST_SWITCH_IN}),
		.q_out(pins_sync)
	);

	// ------------------------------------------------------------------
	// One-second timebase
	// ------------------------------------------------------------------
	logic [31:0] sec_cnt;
	wire sec_tick = (sec_cnt == 32'(SECOND_CYC - 1));

	// Free-running prescaler; every slower timer steps on its tick.
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sec_cnt <= 32'h00000000;
		end else if (sec_tick) begin
			sec_cnt <= 32'h00000000;
		end else begin
			sec_cnt <= sec_cnt + 32'h00000001;
		end
	end

	// ------------------------------------------------------------------
	// Test mode state
	// ------------------------------------------------------------------
	mtp_mode_t mode;
	mtp_mode_t next_mode;
	logic sw_prev;
	logic [15:0] test_sec;
	wire sw_rise = sw_sync && !sw_prev;
	wire test_expired = sec_tick && (test_sec == 16'(TEST_MODE_S - 1));
	wire test_enter = (mode == MTP_NORMAL) && sw_rise;
	wire in_test = (mode == MTP_TEST);

	// Entry ignores the configured mode code; exit is the timeout only,
	// since a supply restart reaches the block as RST_IN.
	always_comb begin
		next_mode = mode;
		case (mode)
			MTP_NORMAL: begin
				if (sw_rise) begin
					next_mode = MTP_TEST;
				end
			end
			MTP_TEST: begin
				if (test_expired) begin
					next_mode = MTP_NORMAL;
				end
			end
			default: begin
				next_mode = MTP_NORMAL;
			end
		endcase
	end

	// Mode register, switch edge history and the test duration timer.
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			mode <= MTP_NORMAL;
			sw_prev <= 1'b0;
			test_sec <= 16'h0000;
		end else begin
			mode <= next_mode;
			sw_prev <= sw_sync;
			if (!in_test) begin
				test_sec <= 16'h0000;
			end else if (sec_tick) begin
				test_sec <= test_sec + 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------------
	// Integration interval selection
	// ------------------------------------------------------------------
	logic [6:0] adapt_s;
	logic activity;
	wire mode_adapt = (INTEG_MODE_IN == MODE_ADAPT_A)
		|| (INTEG_MODE_IN == MODE_ADAPT_B);
	wire mode_fast8 = (INTEG_MODE_IN == MODE_FAST8_A)
		|| (INTEG_MODE_IN == MODE_FAST8_B);
	wire mode_fast2 = (INTEG_MODE_IN == MODE_FAST2);
	// Codes 2 and 6, and any code outside 1..7, fall back to 32 s.
	wire [6:0] cfg_interval = mode_adapt ? adapt_s :
		mode_fast8 ? INTEG_FAST8_S :
		mode_fast2 ? INTEG_FAST2_S : INTEG_NORMAL_S;
	wire [6:0] interval = in_test ? INTEG_TEST_S : cfg_interval;
	wire flow_event = ENERGY_STROBE_IN || VOLUME_STROBE_IN;
	wire [6:0] adapt_double = (adapt_s >= ADAPT_MAX_S) ? ADAPT_MAX_S :
		{adapt_s[5:0], 1'b0};

	// ------------------------------------------------------------------
	// Integration tick generator
	// ------------------------------------------------------------------
	logic [6:0] int_sec;
	logic auto_req;
	wire int_due = sec_tick && ((int_sec + 7'h01) >= interval);
	wire int_fire = int_due || auto_req;

	// A forced auto-integration restarts the interval so that the run
	// begins from a clean boundary.
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			int_sec <= 7'h00;
			INTEG_TICK_OUT <= 1'b0;
			INTEG_INTERVAL_OUT <= INTEG_NORMAL_S;
		end else begin
			INTEG_TICK_OUT <= int_fire;
			INTEG_INTERVAL_OUT <= interval;
			if (int_fire || test_enter) begin
				int_sec <= 7'h00;
			end else if (sec_tick) begin
				int_sec <= int_sec + 7'h01;
			end
		end
	end

	// Adaptive interval: any flow activity drops it to the minimum,
	// a quiet interval doubles it up to the maximum.
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			adapt_s <= ADAPT_MIN_S;
			activity <= 1'b0;
		end else if (int_fire) begin
			adapt_s <= (activity || flow_event) ? ADAPT_MIN_S :
				adapt_double;
			activity <= 1'b0;
		end else if (flow_event) begin
			activity <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Forced dial-up from the arrow keys
	// ------------------------------------------------------------------
	logic [3:0] hold_sec;
	wire both_keys = up_sync && down_sync && in_test;
	wire hold_done = both_keys && !CALL_IND_OUT && (hold_sec >= KEY_HOLD_S);

	// The call indication lights once per key hold; releasing either key
	// or leaving test mode re-arms it.
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			hold_sec <= 4'h0;
			CALL_IND_OUT <= 1'b0;
			AUTO_INTEG_OUT <= 1'b0;
			auto_req <= 1'b0;
		end else begin
			auto_req <= hold_done;
			AUTO_INTEG_OUT <= hold_done;
			if (!both_keys) begin
				hold_sec <= 4'h0;
				CALL_IND_OUT <= 1'b0;
			end else begin
				if (sec_tick && (hold_sec != 4'hf)) begin
					hold_sec <= hold_sec + 4'h1;
				end
				if (hold_done) begin
					CALL_IND_OUT <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Pulse weight by nominal flow size
	// ------------------------------------------------------------------
	// Energy and volume bands share one weight in their own input units.
	wire [15:0] weight = (NOMINAL_FLOW_SIZE_IN <= SIZE_BAND1) ? WEIGHT_BAND1 :
		(NOMINAL_FLOW_SIZE_IN <= SIZE_BAND2) ? WEIGHT_BAND2 :
		(NOMINAL_FLOW_SIZE_IN <= SIZE_BAND3) ? WEIGHT_BAND3 :
		(NOMINAL_FLOW_SIZE_IN <= SIZE_BAND4) ? WEIGHT_BAND4 :
		WEIGHT_BAND5;

	// ------------------------------------------------------------------
	// Verification pulse channels
	// ------------------------------------------------------------------
	wire pulse_en = in_test && adapter_sync;
	logic energy_pulse;
	logic volume_pulse;
	logic [31:0] energy_count;
	logic [31:0] volume_count;

	// Energy channel, weight from 0.001 kWh to 0.01 MWh per pulse.
	mtp_pulse_chan #(
		.WIDTH_CYCLES(PULSE_CYC)
	) u_energy (
		.clk_in(CORE_CLK_IN),
		.rst_in(RST_IN),
		.test_en_in(in_test),
		.pulse_en_in(pulse_en),
		.clear_in(test_enter),
		.weight_in(weight),
		.strobe_in(ENERGY_STROBE_IN),
		.delta_in(ENERGY_DELTA_IN),
		.pulse_out(energy_pulse),
		.count_out(energy_count)
	);

	// Volume channel, weight from 0.01 l to 0.1 m3 per pulse.
	mtp_pulse_chan #(
		.WIDTH_CYCLES(PULSE_CYC)
	) u_volume (
		.clk_in(CORE_CLK_IN),
		.rst_in(RST_IN),
		.test_en_in(in_test),
		.pulse_en_in(pulse_en),
		.clear_in(test_enter),
		.weight_in(weight),
		.strobe_in(VOLUME_STROBE_IN),
		.delta_in(VOLUME_DELTA_IN),
		.pulse_out(volume_pulse),
		.count_out(volume_count)
	);

	// ------------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------------
	// Pulses are gated again here so none leaks once the adapter goes.
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			TEST_MODE_OUT <= 1'b0;
			PULSE_ENABLE_OUT <= 1'b0;
			ENERGY_PULSE_OUT <= 1'b0;
			VOLUME_PULSE_OUT <= 1'b0;
			ENERGY_COUNT_OUT <= 32'h00000000;
			VOLUME_COUNT_OUT <= 32'h00000000;
		end else begin
			TEST_MODE_OUT <= in_test;
			PULSE_ENABLE_OUT <= pulse_en;
			ENERGY_PULSE_OUT <= energy_pulse && pulse_en;
			VOLUME_PULSE_OUT <= volume_pulse && pulse_en;
			ENERGY_COUNT_OUT <= energy_count;
			VOLUME_COUNT_OUT <= volume_count;
		end
	end

endmodule // mtp_top

//--- dv/mtp_top_sva.sv
// Assertion checker for the meter test-mode pulse block.
`timescale 1ns/10ps
module mtp_top_sva
	import mtp_pkg::*;
#(
	parameter int unsigned SECOND_CYC = SECOND_CYCLES,
	parameter int unsigned TEST_MODE_S = TEST_MODE_SECONDS,
	parameter int unsigned PULSE_CYC = PULSE_WIDTH_CYCLES
) (
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	input wire logic TEST_MODE_OUT,
	input wire logic PULSE_ENABLE_OUT,
	input wire logic INTEG_TICK_OUT,
	input wire logic [6:0] INTEG_INTERVAL_OUT,
	input wire logic CALL_IND_OUT,
	input wire logic AUTO_INTEG_OUT,
	input wire logic ENERGY_PULSE_OUT,
	input wire logic VOLUME_PULSE_OUT
);
	// ------------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------------
	logic [31:0] e_hi, v_hi, e_lo, gap, on_cyc;
	logic live1, live;

	// Width, gap and dwell counts; long figures cannot be repetitions.
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			e_hi <= '0;
			v_hi <= '0;
			e_lo <= PULSE_CYC;
			gap <= '0;
			on_cyc <= '0;
			live1 <= 1'b0;
			live <= 1'b0;
		end else begin
			live1 <= 1'b1;
			live <= live1;
			e_hi <= ENERGY_PULSE_OUT ? e_hi + 1 : '0;
			v_hi <= VOLUME_PULSE_OUT ? v_hi + 1 : '0;
			e_lo <= ENERGY_PULSE_OUT ? '0 : e_lo + 1;
			gap <= (INTEG_TICK_OUT || !TEST_MODE_OUT) ? '0 : gap + 1;
			on_cyc <= TEST_MODE_OUT ? on_cyc + 1 : '0;
		end
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	// Checks wait two edges after reset, so that edge functions never
	// compare a value from before or during reset with a settled one.
	default disable iff (RST_IN || !live);

	sequence s_dial;
		AUTO_INTEG_OUT && CALL_IND_OUT && TEST_MODE_OUT
			##1 INTEG_TICK_OUT && !AUTO_INTEG_OUT;
	endsequence
	property p_e_width; $fell(ENERGY_PULSE_OUT) |-> e_hi == PULSE_CYC; endproperty
	property p_v_width; $fell(VOLUME_PULSE_OUT) |-> v_hi == PULSE_CYC; endproperty
	property p_gap; $rose(ENERGY_PULSE_OUT) |-> e_lo >= PULSE_CYC; endproperty
	property p_no_pulse;
		!TEST_MODE_OUT [*3] |-> !(ENERGY_PULSE_OUT || VOLUME_PULSE_OUT);
	endproperty
	property p_enable; PULSE_ENABLE_OUT |-> TEST_MODE_OUT; endproperty
	property p_interval;
		TEST_MODE_OUT |-> INTEG_INTERVAL_OUT == INTEG_TEST_S;
	endproperty
	property p_tick_gap;
		INTEG_TICK_OUT && TEST_MODE_OUT |-> gap <= 2 * SECOND_CYC;
	endproperty
	property p_auto; $rose(AUTO_INTEG_OUT) |-> s_dial; endproperty
	property p_max; TEST_MODE_OUT |-> on_cyc <= TEST_MODE_S * SECOND_CYC; endproperty
	property p_min;
		$fell(TEST_MODE_OUT) |-> on_cyc >= (TEST_MODE_S - 1) * SECOND_CYC;
	endproperty

	a_e_width: assert property (p_e_width) else $error("energy width");
	a_v_width: assert property (p_v_width) else $error("volume width");
	a_gap: assert property (p_gap) else $error("pulses merged");
	a_no_pulse: assert property (p_no_pulse) else $error("stray pulse");
	a_enable: assert property (p_enable) else $error("enable early");
	a_interval: assert property (p_interval) else $error("interval");
	a_tick_gap: assert property (p_tick_gap) else $error("tick late");
	a_auto: assert property (p_auto) else $error("dial-up");
	a_max: assert property (p_max) else $error("test too long");
	a_min: assert property (p_min) else $error("test too short");
endmodule // mtp_top_sva

bind mtp_top mtp_top_sva #(
	.SECOND_CYC(SECOND_CYC),
	.TEST_MODE_S(TEST_MODE_S),
	.PULSE_CYC(PULSE_CYC)
) u_sva (
	.CORE_CLK_IN(CORE_CLK_IN),
	.RST_IN(RST_IN),
	.TEST_MODE_OUT(TEST_MODE_OUT),
	.PULSE_ENABLE_OUT(PULSE_ENABLE_OUT),
	.INTEG_TICK_OUT(INTEG_TICK_OUT),
	.INTEG_INTERVAL_OUT(INTEG_INTERVAL_OUT),
	.CALL_IND_OUT(CALL_IND_OUT),
	.AUTO_INTEG_OUT(AUTO_INTEG_OUT),
	.ENERGY_PULSE_OUT(ENERGY_PULSE_OUT),
	.VOLUME_PULSE_OUT(VOLUME_PULSE_OUT)
);

//--- dv/mtp_adapter_model.sv
// Behavioural model of the external verification pulse adapter.
`timescale 1ns/10ps
module mtp_adapter_model #(
	parameter int unsigned WIDTH = 4
) (
	input wire logic clk_in,
	input wire logic fitted_in,
	input wire logic energy_pulse_in,
	input wire logic volume_pulse_in,
	output logic present_out,
	output int energy_count_out,
	output int volume_count_out,
	output int width_err_out
);
	logic e_q = 1'b0;
	logic v_q = 1'b0;
	int e_w = 0;
	int v_w = 0;
	int e_n = 0;
	int v_n = 0;
	int w_n = 0;

	// Presence only while powered and seated on the meter.
	assign present_out = fitted_in;

	// Each count has a single driver, the clocked process below.
	assign energy_count_out = e_n;
	assign volume_count_out = v_n;
	assign width_err_out = w_n;

	// Count pulses on each pair and time each one against the width.
	always @(posedge clk_in) begin
		e_q <= energy_pulse_in;
		v_q <= volume_pulse_in;
		e_w <= energy_pulse_in ? e_w + 1 : 0;
		v_w <= volume_pulse_in ? v_w + 1 : 0;
		if (energy_pulse_in && !e_q) begin
			e_n <= e_n + 1;
		end
		if (volume_pulse_in && !v_q) begin
			v_n <= v_n + 1;
		end
		if ((!energy_pulse_in && e_q && e_w != WIDTH) ||
			(!volume_pulse_in && v_q && v_w != WIDTH)) begin
			w_n <= w_n + 1;
		end
	end
endmodule // mtp_adapter_model

//--- dv/tb.sv
// Self-checking testbench for the meter test-mode pulse block.
`timescale 1ns/10ps
module tb
	import mtp_pkg::*;
;
	localparam int SEC = 20;
	localparam int TMS = 40;
	localparam int PW = 4;

	logic clk = 1'b0, rst = 1'b1, sw = 1'b0, ku = 1'b0, kd = 1'b0, fit = 1'b0;
	logic es = 1'b0, vs = 1'b0;
	logic [3:0] mode = 4'h2;
	logic [17:0] size = 18'h0000f;
	logic [15:0] ed = 16'h0000, vd = 16'h0000;
	logic tm, pe, tick, call, auto, ep, vp, apr;
	logic [6:0] iv;
	logic [31:0] ec, vc, e0, v0;
	int m_e, m_v, m_err, me, mv, cyc_n = 0, t0;
	int fails = 0, checks = 0;

	// ------------------------------------------------------------------
	// Clock, design and adapter
	// ------------------------------------------------------------------
	always #12.5 clk = ~clk;
	always @(posedge clk) cyc_n <= cyc_n + 1;

	mtp_top #(.SECOND_CYC(SEC), .TEST_MODE_S(TMS), .PULSE_CYC(PW)) dut (
		.CORE_CLK_IN(clk), .RST_IN(rst), .TEST_SWITCH_IN(sw),
		.KEY_UP_IN(ku), .KEY_DOWN_IN(kd), .ADAPTER_PRESENT_IN(apr),
		.INTEG_MODE_IN(mode), .NOMINAL_FLOW_SIZE_IN(size),
		.ENERGY_STROBE_IN(es), .ENERGY_DELTA_IN(ed),
		.VOLUME_STROBE_IN(vs), .VOLUME_DELTA_IN(vd),
		.TEST_MODE_OUT(tm), .PULSE_ENABLE_OUT(pe), .INTEG_TICK_OUT(tick),
		.INTEG_INTERVAL_OUT(iv), .CALL_IND_OUT(call), .AUTO_INTEG_OUT(auto),
		.ENERGY_PULSE_OUT(ep), .VOLUME_PULSE_OUT(vp),
		.ENERGY_COUNT_OUT(ec), .VOLUME_COUNT_OUT(vc));

	mtp_adapter_model #(.WIDTH(PW)) u_adapter (
		.clk_in(clk), .fitted_in(fit), .energy_pulse_in(ep),
		.volume_pulse_in(vp), .present_out(apr), .energy_count_out(m_e),
		.volume_count_out(m_v), .width_err_out(m_err));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	// Bounded wait; a wait that runs out ends the run as a failure.
	task wait_on(input int sel, input logic val, input int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge clk);
			#1;
			if ((sel == 0 ? tm : sel == 1 ? auto : sel == 2 ? pe : call) === val) break;
		end
		if (i == lim) begin
			chk("wait", 32'h0, 32'h1);
			test_done;
		end
	endtask

	// One strobe cycle; inputs change only by non-blocking at an edge.
	task strobe(input logic [15:0] e, input logic [15:0] v);
		@(posedge clk);
		es <= 1'b1;
		vs <= 1'b1;
		ed <= e;
		vd <= v;
		@(posedge clk);
		es <= 1'b0;
		vs <= 1'b0;
	endtask

	task snap;
		e0 = ec;
		v0 = vc;
		me = m_e;
		mv = m_v;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_modes;
		logic [6:0] exp_iv [8];
		exp_iv = '{INTEG_NORMAL_S, 7'h00, INTEG_NORMAL_S, INTEG_FAST8_S,
			INTEG_FAST2_S, 7'h00, INTEG_NORMAL_S, INTEG_FAST8_S};
		#1;
		chk("reset interval", iv, INTEG_NORMAL_S);
		chk("reset test", tm, 1'b0);
		for (int c = 0; c < 8; c++) begin
			@(posedge clk);
			mode <= 4'(c);
			repeat (3) @(posedge clk);
			#1;
			if (exp_iv[c] == 7'h00) begin
				chk("adaptive", iv inside {2, 4, 8, 16, 32, 64}, 1'b1);
			end else begin
				chk("interval", iv, exp_iv[c]);
			end
		end
	endtask

	task t_enter;
		@(posedge clk);
		fit <= 1'b1;
		sw <= 1'b1;
		wait_on(0, 1'b1, 8);
		t0 = cyc_n;
		chk("test interval", iv, INTEG_TEST_S);
		chk("cleared", ec, 32'h0);
		wait_on(2, 1'b1, 6);
	endtask

	task t_pulses;
		logic [17:0] sz [5];
		logic [15:0] w [5];
		sz = '{18'h0000f, 18'h00096, 18'h005dc, 18'h03a98, 18'h03a99};
		w = '{WEIGHT_BAND1, WEIGHT_BAND2, WEIGHT_BAND3, WEIGHT_BAND4,
			WEIGHT_BAND5};
		for (int b = 0; b < 5; b++) begin
			@(posedge clk);
			size <= sz[b];
			#1;
			snap;
			strobe(16'(3 * w[b] - 1), w[b]);
			strobe(16'h0001, 16'h0000);
			repeat (40) @(posedge clk);
			#1;
			chk("energy count", ec, e0 + 3);
			chk("volume count", vc, v0 + 1);
			chk("energy pulses", m_e, me + 3);
			chk("volume pulses", m_v, mv + 1);
		end
	endtask

	task t_adapter;
		@(posedge clk);
		fit <= 1'b0;
		wait_on(2, 1'b0, 6);
		snap;
		strobe(16'h4e20, 16'h2710);
		repeat (30) @(posedge clk);
		#1;
		chk("count unplugged", ec, e0 + 2);
		chk("no pulses", m_e + m_v, me + mv);
		@(posedge clk);
		fit <= 1'b1;
		wait_on(2, 1'b1, 6);
	endtask

	task t_keys;
		@(posedge clk);
		ku <= 1'b1;
		kd <= 1'b1;
		wait_on(1, 1'b1, 4 * SEC + 10);
		chk("call", call, 1'b1);
		@(posedge clk);
		#1;
		chk("forced tick", tick, 1'b1);
		@(posedge clk);
		ku <= 1'b0;
		kd <= 1'b0;
		wait_on(3, 1'b0, 8);
	endtask

	task t_timeout;
		wait_on(0, 1'b0, TMS * SEC + 50);
		chk("dwell", (cyc_n - t0) >= (TMS - 1) * SEC, 1'b1);
		snap;
		strobe(16'h2710, 16'h2710);
		@(posedge clk);
		ku <= 1'b1;
		kd <= 1'b1;
		repeat (4 * SEC + 10) @(posedge clk);
		#1;
		chk("keys ignored", call, 1'b0);
		chk("count held", ec, e0);
		chk("no pulse", m_e, me);
		@(posedge clk);
		ku <= 1'b0;
		kd <= 1'b0;
		sw <= 1'b0;
	endtask

	task t_restart;
		repeat (4) @(posedge clk);
		sw <= 1'b1;
		wait_on(0, 1'b1, 8);
		chk("re-entry cleared", ec, 32'h0);
		// The switch is let go with the restart; a held switch would be
		// seen as a fresh activation once the pins settle.
		@(posedge clk);
		rst <= 1'b1;
		sw <= 1'b0;
		@(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk("restart exit", tm, 1'b0);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_modes;
		t_enter;
		t_pulses;
		t_adapter;
		t_keys;
		t_timeout;
		t_restart;
		chk("width errors", m_err, 32'h0);
		test_done;
	end
endmodule // tb
